// >>> hw/afc_atc_bank.sv
/*
 One address translation cache bank: entry array, round-robin fill,
 masked invalidation and lookup.
 Assumes fill, flush and lookup come from logic on the same clock.
*/
`timescale 1ns/1ps
module afc_atc_bank import afc_pkg::*; #(
   parameter int ENTRIES = 8,
   parameter int PAGE_W = 20
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic fill_i,
   input wire logic fill_global_i,
   input wire logic [2:0] fill_fc_i,
   input wire logic [PAGE_W-1:0] fill_page_i,
   input wire logic flush_i,
   input wire logic [2:0] flush_fc_i,
   input wire logic [2:0] flush_mask_i,
   input wire logic [PAGE_W-1:0] flush_page_i,
   input wire logic flush_use_page_i,
   input wire logic flush_keep_glb_i,
   input wire logic [2:0] look_fc_i,
   input wire logic [PAGE_W-1:0] look_page_i,
   output logic hit_o,
   output logic any_valid_o
);
   localparam int PTR_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(ENTRIES - 1);

   // One cached translation
   typedef struct packed {
      logic valid;
      logic glb;
      logic [2:0] fc;
      logic [PAGE_W-1:0] page;
   } afc_entry_t;

   // Whole bank state
   typedef struct packed {
      afc_entry_t [ENTRIES-1:0] ent;
      logic [PTR_W-1:0] ptr;
   } afc_bank_t;

   afc_bank_t r; // Registered state
   afc_bank_t n; // Next state
   logic [ENTRIES-1:0] hit_vec; // Per-entry lookup match
   logic [ENTRIES-1:0] val_vec; // Per-entry valid

   // Fill first, then flush: an entry filled during the flush cycle is
   // caught too, so nothing stale survives the command
   always_comb begin
      n = r;
      if (fill_i) begin
         n.ent[r.ptr] = '{1'b1, fill_global_i, fill_fc_i, fill_page_i};
         n.ptr = (r.ptr == PTR_LAST) ? '0 : PTR_W'(r.ptr + 1'b1);
      end
      if (flush_i) begin
         for (int k = 0; k < ENTRIES; k++) begin
            // Compare only where the mask holds ones
            if (((n.ent[k].fc & flush_mask_i) == // R2
                 (flush_fc_i & flush_mask_i)) &&
                (!flush_use_page_i || n.ent[k].page == flush_page_i) && // R3
                !(flush_keep_glb_i && n.ent[k].glb)) begin // R12
               n.ent[k].valid = 1'b0;
            end
         end
      end
   end

   // Lookup and occupancy vectors
   for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
      assign hit_vec[g] = r.ent[g].valid && r.ent[g].fc == look_fc_i &&
                          r.ent[g].page == look_page_i;
      assign val_vec[g] = r.ent[g].valid;
   end
   assign hit_o = |hit_vec;
   assign any_valid_o = |val_vec;

   // State register
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule // afc_atc_bank

// >>> hw/afc_flush_ctrl.sv
/*
 Translation cache flush controller: decodes flush commands from the
 integer unit, invalidates entries in one or two cache banks, answers
 translation lookups, and exposes control and status over Avalon-MM.
 Assumes commands, fills and lookups come from logic on clock_i; the
 integer unit supplies the computed effective address and register values.
*/
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module afc_flush_ctrl import afc_pkg::*; #(
   parameter int ENTRIES = 8,
   parameter int PAGE_W = 20
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Decoded command from the integer unit
   input wire logic cmd_valid_i,
   input wire logic cmd_supervisor_i,
   input wire logic [15:0] cmd_op_i,
   input wire logic [15:0] cmd_ext_i,
   input wire logic [31:0] cmd_ea_i,
   input wire logic [7:0][2:0] data_reg_low_i,
   input wire logic [7:0][31:0] address_register_i,
   input wire logic [2:0] source_space_code_reg_i,
   input wire logic [2:0] destination_space_code_reg_i,
   output logic cmd_ready_o,
   output logic cmd_done_o,
   output logic priv_trap_o,
   output logic illegal_o,
   // Table walker fill
   input wire logic fill_valid_i,
   input wire logic fill_instr_i,
   input wire logic fill_global_i,
   input wire logic [2:0] fill_fc_i,
   input wire logic [31:0] fill_addr_i,
   // Translation lookup
   input wire logic lookup_valid_i,
   input wire logic lookup_instr_i,
   input wire logic [2:0] lookup_fc_i,
   input wire logic [31:0] lookup_addr_i,
   output logic lookup_ready_o,
   output logic lookup_ack_o,
   output logic lookup_hit_o
);
   // Controller states
   typedef enum logic [1:0] {
      afc_idle,
      afc_exec,
      afc_stall
   } afc_state_t;

   // All controller state
   typedef struct packed {
      afc_state_t st;
      logic ready;
      logic done;
      logic trap;
      logic illegal;
      logic look_rdy;
      logic look_ack;
      logic look_hit;
      logic flush_en;
      logic f_both;
      logic [2:0] f_fc;
      logic [2:0] f_mask;
      logic [PAGE_W-1:0] f_page;
      logic f_use_page;
      logic f_keep_glb;
      logic [1:0] variant;
      logic [15:0] stall_ld;
      logic [15:0] stall_cnt;
      logic [15:0] count;
      logic waitreq;
      logic [31:0] rdata;
   } afc_regs_t;

   afc_regs_t r; // Registered state
   afc_regs_t n; // Next state

   logic hit_i; // Instruction bank hit
   logic hit_d; // Data bank hit
   logic any_i; // Instruction bank holds entries
   logic any_d; // Data bank holds entries

   // Single-form fields
   logic sgl_ok; // Opcode and extension prefixes match
   logic [2:0] ea_mode; // Effective address mode
   logic [2:0] ea_reg; // Effective address register
   logic [2:0] s_mode; // Flush mode field
   logic [2:0] s_mask; // Function code mask
   logic [4:0] s_fcf; // Function code source field
   logic ea_ok; // Address mode is control alterable
   logic fc_ok; // Function code source is legal
   logic [2:0] fc_val; // Resolved function code
   logic mode_ok; // Mode field is one we implement
   // Dual-form fields
   logic dual_ok; // Dual opcode prefix matches
   logic [1:0] opm; // Opmode
   logic [2:0] an_sel; // Address register select
   logic accept; // Command taken this cycle

   assign accept = cmd_valid_i && r.ready;

   // Single form decode
   assign sgl_ok = cmd_op_i[15:6] == AFC_SGL_PFX &&
                   cmd_ext_i[15:13] == AFC_SGL_EXT_PFX &&
                   cmd_ext_i[9:8] == 2'h0;
   assign ea_mode = cmd_op_i[5:3];
   assign ea_reg = cmd_op_i[2:0];
   assign s_mode = cmd_ext_i[12:10];
   assign s_mask = cmd_ext_i[7:5];
   assign s_fcf = cmd_ext_i[4:0];
   // Postincrement, predecrement, direct, immediate, PC modes refused
   assign ea_ok = ea_mode == AFC_EA_IND || ea_mode == AFC_EA_DISP || // R6
                  ea_mode == AFC_EA_IDX ||
                  (ea_mode == AFC_EA_ABS &&
                   (ea_reg == AFC_EA_ABS_W || ea_reg == AFC_EA_ABS_L));
   assign mode_ok = s_mode == AFC_MODE_ALL || s_mode == AFC_MODE_FC || // R1
                    (s_mode == AFC_MODE_FC_EA && ea_ok);

   // Function code source
   always_comb begin
      fc_ok = 1'b1;
      fc_val = 3'h0;
      if (s_fcf[4:3] == AFC_FCSRC_IMM) begin
         fc_val = s_fcf[2:0]; // R5
      end else if (s_fcf[4:3] == AFC_FCSRC_DREG) begin
         fc_val = data_reg_low_i[s_fcf[2:0]]; // R5
      end else if (s_fcf == AFC_FCSRC_SRC) begin
         fc_val = source_space_code_reg_i; // R5
      end else if (s_fcf == AFC_FCSRC_DST) begin
         fc_val = destination_space_code_reg_i; // R5
      end else begin
         fc_ok = 1'b0; // Other codes have no meaning
      end
   end

   // Dual form decode
   assign dual_ok = cmd_op_i[15:5] == AFC_DUAL_PFX;
   assign opm = cmd_op_i[4:3]; // R14
   assign an_sel = cmd_op_i[2:0]; // R14

   // Next-state logic: bus slave, lookup port and command sequencer
   always_comb begin
      n = r;
      n.done = 1'b0;
      n.trap = 1'b0;
      n.illegal = 1'b0;
      n.look_ack = 1'b0;
      n.flush_en = 1'b0;
      // Bus: one wait cycle, then answer for exactly one cycle
      if ((avs_read_i || avs_write_i) && r.waitreq) begin
         n.waitreq = 1'b0;
         unique case (avs_address_i)
            AFC_OFS_CTRL: n.rdata = {30'h0, r.variant};
            AFC_OFS_STATUS: n.rdata = {29'h0, any_d, any_i, r.st != afc_idle};
            AFC_OFS_COUNT: n.rdata = {16'h0, r.count};
            AFC_OFS_STALL: n.rdata = {16'h0, r.stall_ld};
            default: n.rdata = 32'h0; // Unmapped reads as zero
         endcase
      end else begin
         n.waitreq = 1'b1;
      end
      // Write lands at the edge where waitrequest is seen low
      if (avs_write_i && !r.waitreq) begin
         unique case (avs_address_i)
            AFC_OFS_CTRL: n.variant = avs_writedata_i[AFC_CTRL_VAR_LSB +: 2];
            AFC_OFS_COUNT: n.count = 16'h0; // Any write clears except in the cycle a flush completes
            AFC_OFS_STALL: n.stall_ld = avs_writedata_i[15:0];
            default: ; // Status and unmapped ignore writes
         endcase
      end
      // Lookups only while no flush is pending
      if (lookup_valid_i && r.look_rdy) begin // R16
         n.look_ack = 1'b1;
         n.look_hit = lookup_instr_i ? hit_i : hit_d;
      end
      // Command sequencer
      unique case (r.st)
         afc_idle: begin
            if (accept) begin
               if (!cmd_supervisor_i) begin
                  n.trap = 1'b1; // R8
               end else if (r.variant == afc_var_single) begin
                  if (sgl_ok && mode_ok && (fc_ok || s_mode == AFC_MODE_ALL))
                  begin
                     n.flush_en = 1'b1;
                     n.f_both = 1'b0;
                     n.f_keep_glb = 1'b0;
                     // Flush-all ignores mask and code fields
                     n.f_mask = (s_mode == AFC_MODE_ALL) ? 3'h0 : s_mask; // R1
                     n.f_fc = fc_val;
                     n.f_use_page = s_mode == AFC_MODE_FC_EA; // R3
                     // The address itself, never memory behind it
                     n.f_page = cmd_ea_i[31 -: PAGE_W]; // R7
                  end else begin
                     n.illegal = 1'b1; // R6
                  end
               end else if (dual_ok) begin
                  if (r.variant == afc_var_dual) begin
                     n.flush_en = 1'b1;
                     n.f_both = 1'b1; // R9
                     n.f_fc = destination_space_code_reg_i; // R10 R11
                     n.f_mask = AFC_MASK_FULL;
                     n.f_page = address_register_i[an_sel][31 -: PAGE_W]; // R10
                     n.f_use_page = opm == AFC_OPM_PAGE_NG || // R13
                                    opm == AFC_OPM_PAGE;
                     n.f_keep_glb = opm == AFC_OPM_PAGE_NG || // R12
                                    opm == AFC_OPM_ALL_NG;
                     // Flush-all forms ignore the code entirely
                     if (opm == AFC_OPM_ALL || opm == AFC_OPM_ALL_NG) begin
                        n.f_mask = 3'h0; // R13
                     end
                  end else begin
                     // No caches: stall, then carry on
                     n.st = afc_stall; // R15
                     n.stall_cnt = r.stall_ld;
                  end
               end else begin
                  n.illegal = 1'b1;
               end
               if (n.flush_en) begin
                  n.st = afc_exec;
               end
               if (n.st != afc_idle) begin
                  n.ready = 1'b0;
                  n.look_rdy = 1'b0; // R16
               end
            end
         end
         afc_exec: begin
            // Banks invalidate at this edge; lookups reopen after it
            n.st = afc_idle; // R16
            n.done = 1'b1;
            n.ready = 1'b1;
            n.look_rdy = 1'b1;
            n.count = r.count + 16'h1;
         end
         afc_stall: begin
            if (r.stall_cnt == 16'h0) begin
               n.st = afc_idle; // R15
               n.done = 1'b1;
               n.ready = 1'b1;
               n.look_rdy = 1'b1;
            end else begin
               n.stall_cnt = r.stall_cnt - 16'h1;
            end
         end
         default: begin
            // Unused state code recovers to idle
            n.st = afc_idle;
            n.ready = 1'b1;
            n.look_rdy = 1'b1;
         end
      endcase
   end

   // State register; waitrequest and ready rise out of reset
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         r <= '0;
         r.ready <= 1'b1;
         r.look_rdy <= 1'b1;
         r.waitreq <= 1'b1;
         r.variant <= AFC_CTRL_RST;
         r.stall_ld <= AFC_STALL_RST;
      end else begin
         r <= n;
      end
   end

   // Instruction bank: only the dual form reaches it
   afc_atc_bank #(.ENTRIES(ENTRIES), .PAGE_W(PAGE_W)) u_ibank (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .fill_i(fill_valid_i && fill_instr_i),
      .fill_global_i(fill_global_i),
      .fill_fc_i(fill_fc_i),
      .fill_page_i(fill_addr_i[31 -: PAGE_W]),
      .flush_i(r.flush_en && r.f_both), // R9
      .flush_fc_i(r.f_fc),
      .flush_mask_i(r.f_mask),
      .flush_page_i(r.f_page),
      .flush_use_page_i(r.f_use_page),
      .flush_keep_glb_i(r.f_keep_glb),
      .look_fc_i(lookup_fc_i),
      .look_page_i(lookup_addr_i[31 -: PAGE_W]),
      .hit_o(hit_i),
      .any_valid_o(any_i)
   );

   // Data bank: both the single and the dual form reach it
   afc_atc_bank #(.ENTRIES(ENTRIES), .PAGE_W(PAGE_W)) u_dbank (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .fill_i(fill_valid_i && !fill_instr_i),
      .fill_global_i(fill_global_i),
      .fill_fc_i(fill_fc_i),
      .fill_page_i(fill_addr_i[31 -: PAGE_W]),
      .flush_i(r.flush_en),
      .flush_fc_i(r.f_fc),
      .flush_mask_i(r.f_mask),
      .flush_page_i(r.f_page),
      .flush_use_page_i(r.f_use_page),
      .flush_keep_glb_i(r.f_keep_glb),
      .look_fc_i(lookup_fc_i),
      .look_page_i(lookup_addr_i[31 -: PAGE_W]),
      .hit_o(hit_d),
      .any_valid_o(any_d)
   );

   // Outputs straight from the state register
   assign avs_readdata_o = r.rdata;
   assign avs_waitrequest_o = r.waitreq;
   assign cmd_ready_o = r.ready;
   assign cmd_done_o = r.done;
   assign priv_trap_o = r.trap;
   assign illegal_o = r.illegal;
   assign lookup_ready_o = r.look_rdy;
   assign lookup_ack_o = r.look_ack;
   assign lookup_hit_o = r.look_hit;

   // User state: trap next cycle, no flush ever started
   property p_user_trap;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && !cmd_supervisor_i |=> priv_trap_o && !r.flush_en;
   endproperty
   a_user_trap: assert property (p_user_trap) // R8
      else $error("user flush did not trap");

   // Flush-all in single form clears every data entry two edges later
   property p_sgl_all;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && cmd_supervisor_i && r.variant == afc_var_single &&
      sgl_ok && s_mode == AFC_MODE_ALL |-> ##2 !any_d;
   endproperty
   a_sgl_all: assert property (p_sgl_all) // R1
      else $error("flush all left data entries");

   // Mask is carried to the banks unchanged in code mode
   property p_mask_pass;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && cmd_supervisor_i && r.variant == afc_var_single &&
      sgl_ok && s_mode == AFC_MODE_FC && fc_ok
      |=> r.flush_en && r.f_mask == $past(s_mask) && !r.f_use_page;
   endproperty
   a_mask_pass: assert property (p_mask_pass) // R2
      else $error("function code mask not applied");

   // Postincrement address mode is refused
   property p_bad_ea;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && cmd_supervisor_i && r.variant == afc_var_single &&
      s_mode == AFC_MODE_FC_EA && ea_mode == 3'h3
      |=> illegal_o && !r.flush_en && cmd_ready_o;
   endproperty
   a_bad_ea: assert property (p_bad_ea) // R6
      else $error("bad address mode not refused");

   // Destination code source selects the destination register
   property p_fc_dst;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && cmd_supervisor_i && r.variant == afc_var_single &&
      sgl_ok && s_mode == AFC_MODE_FC && s_fcf == AFC_FCSRC_DST
      |=> r.f_fc == $past(destination_space_code_reg_i);
   endproperty
   a_fc_dst: assert property (p_fc_dst) // R5
      else $error("destination code source wrong");

   // Dual flush-all empties both banks
   property p_dual_all;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && cmd_supervisor_i && r.variant == afc_var_dual &&
      dual_ok && opm == AFC_OPM_ALL |-> ##2 (!any_i && !any_d);
   endproperty
   a_dual_all: assert property (p_dual_all) // R9
      else $error("dual flush all left entries");

   // Non-global variants keep global entries
   property p_keep_glb;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && cmd_supervisor_i && r.variant == afc_var_dual && dual_ok &&
      (opm == AFC_OPM_ALL_NG || opm == AFC_OPM_PAGE_NG)
      |=> r.f_keep_glb && r.f_both;
   endproperty
   a_keep_glb: assert property (p_keep_glb) // R12
      else $error("global entries not protected");

   // Page flush enables the page match and takes the destination code
   property p_dual_page;
      @(posedge clock_i) disable iff (sys_rst_i)
      accept && cmd_supervisor_i && r.variant == afc_var_dual &&
      dual_ok && opm == AFC_OPM_PAGE
      |=> r.f_use_page && !r.f_keep_glb &&
          r.f_fc == $past(destination_space_code_reg_i);
   endproperty
   a_dual_page: assert property (p_dual_page) // R13
      else $error("page flush fields wrong");

   // No lookup is served between acceptance and completion
   property p_no_look;
      @(posedge clock_i) disable iff (sys_rst_i)
      r.flush_en |-> !lookup_ready_o ##1 (cmd_done_o && lookup_ready_o);
   endproperty
   a_no_look: assert property (p_no_look) // R16
      else $error("lookup open during flush");

   // Cacheless variant never invalidates
   property p_none_idle;
      @(posedge clock_i) disable iff (sys_rst_i)
      r.st == afc_stall |-> !r.flush_en && !cmd_ready_o;
   endproperty
   a_none_idle: assert property (p_none_idle) // R15
      else $error("cacheless variant flushed");
endmodule // afc_flush_ctrl

// >>> hw/afc_pkg.sv
/*
 Shared constants for the translation cache flush controller: register map,
 reset values, instruction word layouts and variant encodings.
 Assumes a single processor clock and a synchronous active high reset.
*/
// Summary of operation
// [R1] Single form mode selects all, code, code+address
// [R2] Mask ones pick compared function code bits
// [R3] Address flush kills one page per code
// [R4] Flush-all issuer sends zero mask and code
// [R5] Code source: immediate, data register, source, destination
// [R6] Only control alterable address modes are accepted
// [R7] Computed address itself is the flushed address
// [R8] User state traps, touches no entry
// [R9] Dual form flushes both caches together
// [R10] Dual page flush matches address and destination
// [R11] Destination code 1,2 user; 5,6 supervisor
// [R12] Non-global variants keep global entries intact
// [R13] Opmode: page-nonglobal, page, all-nonglobal, all
// [R14] Opmode in bits 4:3, register in 2:0
// [R15] Cacheless variant stalls, then does nothing
// [R16] Flush completes before the next translation
package afc_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [3:0] AFC_OFS_CTRL = 4'h0;
   localparam logic [3:0] AFC_OFS_STATUS = 4'h4;
   localparam logic [3:0] AFC_OFS_COUNT = 4'h8;
   localparam logic [3:0] AFC_OFS_STALL = 4'hc;
   // Control register: variant select in the low bits
   localparam int AFC_CTRL_VAR_LSB = 0;
   localparam logic [1:0] AFC_CTRL_RST = 2'h0;
   // Status bit positions
   localparam int AFC_STAT_BUSY = 0;
   localparam int AFC_STAT_IANY = 1;
   localparam int AFC_STAT_DANY = 2;
   // Stall length for the cacheless variant, in clocks
   localparam logic [15:0] AFC_STALL_RST = 16'h0010;
   // Device variants
   typedef enum logic [1:0] {
      afc_var_single,
      afc_var_dual,
      afc_var_none
   } afc_variant_t;
   // Single-cache form words
   localparam logic [9:0] AFC_SGL_PFX = 10'h3c0;
   localparam logic [2:0] AFC_SGL_EXT_PFX = 3'h1;
   localparam logic [2:0] AFC_MODE_ALL = 3'h1;
   localparam logic [2:0] AFC_MODE_FC = 3'h4;
   localparam logic [2:0] AFC_MODE_FC_EA = 3'h6;
   localparam logic [1:0] AFC_FCSRC_IMM = 2'h2;
   localparam logic [1:0] AFC_FCSRC_DREG = 2'h1;
   localparam logic [4:0] AFC_FCSRC_SRC = 5'h00;
   localparam logic [4:0] AFC_FCSRC_DST = 5'h01;
   // Effective address modes allowed for the page flush
   localparam logic [2:0] AFC_EA_IND = 3'h2;
   localparam logic [2:0] AFC_EA_DISP = 3'h5;
   localparam logic [2:0] AFC_EA_IDX = 3'h6;
   localparam logic [2:0] AFC_EA_ABS = 3'h7;
   localparam logic [2:0] AFC_EA_ABS_W = 3'h0;
   localparam logic [2:0] AFC_EA_ABS_L = 3'h1;
   // Dual-cache form word
   localparam logic [10:0] AFC_DUAL_PFX = 11'h7a8;
   localparam logic [1:0] AFC_OPM_PAGE_NG = 2'h0;
   localparam logic [1:0] AFC_OPM_PAGE = 2'h1;
   localparam logic [1:0] AFC_OPM_ALL_NG = 2'h2;
   localparam logic [1:0] AFC_OPM_ALL = 2'h3;
   localparam logic [2:0] AFC_MASK_FULL = 3'h7;
endpackage

// >>> testbench/afc_iu_model.sv
/*
 Integer unit model: offers one decoded flush command at a time.
 Assumes the controller takes a command on an edge with ready high.
*/
`timescale 1ns/1ps
module afc_iu_model (
   input wire logic clock_i,
   input wire logic cmd_ready_i,
   output logic cmd_valid_o,
   output logic cmd_super_o,
   output logic [15:0] cmd_op_o,
   output logic [15:0] cmd_ext_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_super_o = 1'b0;
      cmd_op_o = 16'h0000;
      cmd_ext_o = 16'h0000;
   end
   // Offer held until the taking edge, then words inverted, never stale
   task automatic issue(input logic s, input logic [15:0] op, ext);
      int n;
      @(posedge clock_i);
      cmd_valid_o <= 1'b1;
      cmd_super_o <= s;
      cmd_op_o <= op;
      cmd_ext_o <= (ext[12:10] == 3'h1) ? {ext[15:8], 8'h00} : ext;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (cmd_ready_i !== 1'b1 && n < 64);
      cmd_valid_o <= 1'b0;
      cmd_op_o <= ~op;
      cmd_ext_o <= ~ext;
   endtask
endmodule // afc_iu_model

// >>> testbench/atc_flush_control_tb.sv
/*
 Bench for the flush controller: registers, fills, lookups, flushes.
 Assumes afc_pkg and the integer unit model are compiled first.
*/
`timescale 1ns/1ps
module atc_flush_control_tb;
   import afc_pkg::*;
   logic clock_i = 0, sys_rst_i = 1, rd = 0, wr = 0, wreq, cv, cs, rdy;
   logic done, trap, ill, fv = 0, fi = 0, fg = 0, lv = 0, li = 0;
   logic lrdy, lack, lhit;
   logic [3:0] adr = 0;
   logic [31:0] wdat = 0, rdat, ea = 0, fa = 0, la = 0, q;
   logic [15:0] op, ext;
   logic [7:0][2:0] dlo = '0;
   logic [7:0][31:0] areg = '0;
   logic [2:0] source_space_code_reg = 0, dfc = 5, ffc = 0, lfc = 0;
   int mismatches = 0, num_checks = 0;
   afc_flush_ctrl DUT (.clock_i, .sys_rst_i, .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .cmd_valid_i(cv),
      .cmd_supervisor_i(cs), .cmd_op_i(op), .cmd_ext_i(ext),
      .cmd_ea_i(ea), .data_reg_low_i(dlo), .address_register_i(areg),
      .source_space_code_reg_i(source_space_code_reg), .destination_space_code_reg_i(dfc),
      .cmd_ready_o(rdy), .cmd_done_o(done), .priv_trap_o(trap),
      .illegal_o(ill), .fill_valid_i(fv), .fill_instr_i(fi),
      .fill_global_i(fg), .fill_fc_i(ffc), .fill_addr_i(fa),
      .lookup_valid_i(lv), .lookup_instr_i(li), .lookup_fc_i(lfc),
      .lookup_addr_i(la), .lookup_ready_o(lrdy), .lookup_ack_o(lack),
      .lookup_hit_o(lhit));
   afc_iu_model iu (.clock_i, .cmd_ready_i(rdy), .cmd_valid_o(cv),
      .cmd_super_o(cs), .cmd_op_o(op), .cmd_ext_o(ext));
   initial forever #50 clock_i = ~clock_i;
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // Wait for a level under a bound; running out ends the run
   task automatic wt(ref logic s, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (s !== v && n < 50);
      if (n >= 50) begin
         mismatches++;
         final_report();
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clock_i);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      wt(wreq, 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic fill(input logic i, g, input logic [2:0] c,
      input logic [31:0] a);
      @(posedge clock_i);
      {fv, fi, fg, ffc, fa} <= {1'b1, i, g, c, a};
      @(posedge clock_i);
      fv <= 1'b0;
   endtask
   task automatic look(input logic i, input logic [2:0] c, input logic e);
      @(posedge clock_i);
      {lv, li, lfc, la} <= {1'b1, i, c, 32'h0001_2345};
      wt(lrdy, 1'b1);
      lv <= 1'b0;
      @(posedge clock_i);
      chk("hit", {1'b1, e}, {lack, lhit});
   endtask
   // Outcome flags {done, trap, illegal} of one command
   task automatic run(input logic s, input logic [15:0] o, x,
      input logic [2:0] e);
      logic [2:0] f;
      iu.issue(s, o, x);
      f = 3'h0;
      for (int n = 0; n < 40 && f == 3'h0; n++) begin
         @(posedge clock_i);
         f = {done, trap, ill};
      end
      chk("outcome", e, f);
   endtask
   task automatic t_single();
      fill(0, 0, 5, 32'h0001_2000);
      fill(0, 0, 6, 32'h0001_2000);
      ea <= 32'h0001_2abc;
      run(0, 16'hf000, 16'h3095, 3'h2);
      look(0, 6, 1);
      run(1, 16'hf018, 16'h38f5, 3'h1);
      run(1, 16'hf010, 16'h38f5, 3'h4);
      look(0, 5, 0);
      look(0, 6, 1);
      run(1, 16'hf000, 16'h3081, 3'h4);
      look(0, 6, 0);
      fill(0, 0, 2, 32'h0001_2000);
      run(1, 16'hf000, 16'h2400, 3'h4);
      look(0, 2, 0);
      bus(0, AFC_OFS_COUNT, 0);
      chk("count", 32'h3, q);
      $display("test single done");
   endtask
   task automatic t_dual();
      bus(1, AFC_OFS_CTRL, 32'h1);
      fill(1, 1, 5, 32'h0001_2000);
      fill(0, 0, 5, 32'h0001_2000);
      run(1, 16'hf510, 16'h0000, 3'h4);
      look(1, 5, 1);
      look(0, 5, 0);
      areg[3] <= 32'h0001_2000;
      run(1, 16'hf50b, 16'h0000, 3'h4);
      look(1, 5, 0);
      fill(1, 0, 6, 32'h0001_2000);
      run(1, 16'hf518, 16'h0000, 3'h4);
      look(1, 6, 0);
      $display("test dual done");
   endtask
   // Cacheless variant: stall then no flush; count write clears
   task automatic t_none();
      bus(1, AFC_OFS_CTRL, 32'h2);
      fill(0, 0, 5, 32'h0001_2000);
      run(0, 16'hf510, 16'h0000, 3'h2);
      run(1, 16'hf510, 16'h0000, 3'h4);
      look(0, 5, 1);
      bus(0, AFC_OFS_COUNT, 0);
      chk("count", 32'h6, q);
      bus(1, AFC_OFS_COUNT, 0);
      bus(0, AFC_OFS_COUNT, 0);
      chk("cleared", 32'h0, q);
      $display("test none done");
   endtask
   initial begin
      repeat (16) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      bus(0, AFC_OFS_STALL, 0);
      chk("stall", 32'h10, q);
      bus(0, 4'h2, 0);
      chk("unmapped", 32'h0, q);
      bus(0, AFC_OFS_STATUS, 0);
      chk("status", 32'h0, q);
      $display("test regs done");
      t_single();
      t_dual();
      t_none();
      final_report();
   end
endmodule // atc_flush_control_tb
